// >>> inc/isp_pkg.sv
package isp_pkg;

  // instruction register
  localparam int          IR_W         = 4;
  localparam logic [3:0]  IR_CAPTURE   = 4'h1;
  localparam logic [3:0]  INS_IDCODE   = 4'h1;
  localparam logic [3:0]  INS_ENABLE   = 4'h9;
  localparam logic [3:0]  INS_ERASE    = 4'hA;
  localparam logic [3:0]  INS_PROGRAM  = 4'hB;
  localparam logic [3:0]  INS_VERIFY   = 4'hC;
  localparam logic [3:0]  INS_BYPASS   = 4'hF;
  localparam logic [3:0]  IR_RESET     = INS_IDCODE;

  // identification word, value is arbitrary; bit 0 must stay 1
  localparam logic [31:0] ID_WORD      = 32'h0A5C_3001;
  localparam int          ID_W         = 32;

  // array geometry and isp shift register layout {row address, row data}
  localparam int          ROW_W        = 16;
  localparam int          ROW_ADDR_W   = 5;
  localparam int          ROWS         = 32;
  localparam int          ISP_W        = ROW_W + ROW_ADDR_W;
  localparam int          DR_W         = 32;
  localparam int          BYP_W        = 1;
  localparam int          USER_IO_W    = 8;

  // operation codes carried across the clock crossing
  typedef enum logic [1:0] {
    OP_ERASE   = 2'h0,
    OP_PROGRAM = 2'h1,
    OP_VERIFY  = 2'h2
  } nv_op_t;

  // tap controller, one-hot
  typedef enum logic [15:0] {
    TAP_RESET    = 16'h0001,
    TAP_IDLE     = 16'h0002,
    TAP_SEL_DR   = 16'h0004,
    TAP_CAP_DR   = 16'h0008,
    TAP_SHIFT_DR = 16'h0010,
    TAP_EXIT1_DR = 16'h0020,
    TAP_PAUSE_DR = 16'h0040,
    TAP_EXIT2_DR = 16'h0080,
    TAP_UPD_DR   = 16'h0100,
    TAP_SEL_IR   = 16'h0200,
    TAP_CAP_IR   = 16'h0400,
    TAP_SHIFT_IR = 16'h0800,
    TAP_EXIT1_IR = 16'h1000,
    TAP_PAUSE_IR = 16'h2000,
    TAP_EXIT2_IR = 16'h4000,
    TAP_UPD_IR   = 16'h8000
  } tap_state_t;

endpackage

// >>> logic/jtag_isp_unit.sv
// Overview of operation
// - erase, program and verify act only after an enable instruction, and an enable stays in effect across later isp instructions.
// - code 1001 selects the isp shift register and unlocks erase, program and verify.
// - code 1010 with isp enabled clears every row of the array in one bulk operation.
// - code 1011 with isp enabled writes the isp shift register data into the addressed row.
// - code 1100 with isp enabled copies the addressed row into the isp shift register for shifting out.
// - during verify the user outputs take the configured verify pattern instead of a fixed state.
// - data input is taken on the rising test clock, data output changes on the falling edge and floats when idle.
// - code 1111 and any ir scan with data input high give a one-bit bypass stage.
// - code 0001 places the identification register between data input and output.
// - with no test reset pin, the power-up reset clears the tap controller and instruction logic.
`timescale 1ns/10ps
module jtag_isp_unit (
  // system side
  input  wire logic                           sys_clk_i,
  input  wire logic                           rstn_i,
  // test access port
  input  wire logic                           tck_i,
  input  wire logic                           tms_i,
  input  wire logic                           tdi_i,
  output logic                                tdo_o,
  output logic                                tdo_oe_o,
  // user i/o
  input  wire logic [isp_pkg::USER_IO_W-1:0]  user_out_i,
  input  wire logic [isp_pkg::USER_IO_W-1:0]  verify_io_cfg_i,
  output logic      [isp_pkg::USER_IO_W-1:0]  user_io_o,
  // status
  output logic                                nv_busy_o
);
  import isp_pkg::*;

  function automatic logic is_op(input logic [IR_W-1:0] ins);
    is_op = (ins == INS_ERASE) || (ins == INS_PROGRAM) || (ins == INS_VERIFY);
  endfunction

  function automatic logic is_isp(input logic [IR_W-1:0] ins);
    is_isp = is_op(ins) || (ins == INS_ENABLE);
  endfunction

  // tck domain state
  tap_state_t             state_reg,   state_next;
  logic [IR_W-1:0]        ir_sh_reg,   ir_sh_next;
  logic [IR_W-1:0]        ir_reg,      ir_next;
  logic [DR_W-1:0]        dr_reg,      dr_next;
  logic [ISP_W-1:0]       isp_reg,     isp_next;
  logic                   isp_en_reg,  isp_en_next;
  logic                   armed_reg,   armed_next;
  logic                   req_reg,     req_next;
  nv_op_t                 op_reg,      op_next;
  logic [ROW_W-1:0]       rb_reg,      rb_next;
  logic                   ack_s1_reg,  ack_s2_reg, ack_seen_reg, ack_seen_next;
  logic                   vfy_reg,     vfy_next;
  logic                   tdo_reg,     tdo_next;
  logic                   oe_reg,      oe_next;

  // sys domain state
  logic                   req_s1_reg,  req_s2_reg;
  logic                   ack_reg,     ack_next;
  logic                   busy_reg,    busy_next;
  logic [ROW_W-1:0]       rd_reg,      rd_next;
  logic                   vfy_s1_reg,  vfy_s2_reg;
  logic [USER_IO_W-1:0]   uio_reg,     uio_next;
  logic                   mem_we,      mem_clr;
  logic [ROW_W-1:0]       mem [ROWS];

  logic                   pending;
  logic                   ack_edge;
  logic [IR_W-1:0]        dec_ir;

  assign pending  = (req_reg != ack_seen_reg);
  assign ack_edge = (ack_s2_reg != ack_seen_reg);
  // an op code without a live enable falls back to bypass
  assign dec_ir   = (is_op(ir_reg) && !isp_en_reg) ? INS_BYPASS : ir_reg;

  // tap controller, sampled on rising tck
  always_comb begin
    state_next = TAP_RESET;
    case (state_reg)
      TAP_RESET:    state_next = tms_i ? TAP_RESET    : TAP_IDLE;
      TAP_IDLE:     state_next = tms_i ? TAP_SEL_DR   : TAP_IDLE;
      TAP_SEL_DR:   state_next = tms_i ? TAP_SEL_IR   : TAP_CAP_DR;
      TAP_CAP_DR:   state_next = tms_i ? TAP_EXIT1_DR : TAP_SHIFT_DR;
      TAP_SHIFT_DR: state_next = tms_i ? TAP_EXIT1_DR : TAP_SHIFT_DR;
      TAP_EXIT1_DR: state_next = tms_i ? TAP_UPD_DR   : TAP_PAUSE_DR;
      TAP_PAUSE_DR: state_next = tms_i ? TAP_EXIT2_DR : TAP_PAUSE_DR;
      TAP_EXIT2_DR: state_next = tms_i ? TAP_UPD_DR   : TAP_SHIFT_DR;
      TAP_UPD_DR:   state_next = tms_i ? TAP_SEL_DR   : TAP_IDLE;
      TAP_SEL_IR:   state_next = tms_i ? TAP_RESET    : TAP_CAP_IR;
      TAP_CAP_IR:   state_next = tms_i ? TAP_EXIT1_IR : TAP_SHIFT_IR;
      TAP_SHIFT_IR: state_next = tms_i ? TAP_EXIT1_IR : TAP_SHIFT_IR;
      TAP_EXIT1_IR: state_next = tms_i ? TAP_UPD_IR   : TAP_PAUSE_IR;
      TAP_PAUSE_IR: state_next = tms_i ? TAP_EXIT2_IR : TAP_PAUSE_IR;
      TAP_EXIT2_IR: state_next = tms_i ? TAP_UPD_IR   : TAP_SHIFT_IR;
      TAP_UPD_IR:   state_next = tms_i ? TAP_SEL_DR   : TAP_IDLE;
      default:      state_next = TAP_RESET;
    endcase
  end

  // instruction, data path and request logic
  always_comb begin
    ir_sh_next    = ir_sh_reg;
    ir_next       = ir_reg;
    dr_next       = dr_reg;
    isp_next      = isp_reg;
    isp_en_next   = isp_en_reg;
    armed_next    = armed_reg;
    req_next      = req_reg;
    op_next       = op_reg;
    rb_next       = rb_reg;
    ack_seen_next = ack_seen_reg;
    case (state_reg)
      TAP_RESET: begin
        ir_next     = IR_RESET;
        isp_en_next = 1'b0;
        armed_next  = 1'b0;
      end
      TAP_CAP_IR:   ir_sh_next = IR_CAPTURE;
      // a scan with tdi held high leaves all ones, the bypass code
      TAP_SHIFT_IR: ir_sh_next = {tdi_i, ir_sh_reg[IR_W-1:1]};
      TAP_UPD_IR: begin
        ir_next    = ir_sh_reg;
        armed_next = 1'b1;
        if (ir_sh_reg == INS_ENABLE) begin
          isp_en_next = 1'b1;
        end else if (!is_isp(ir_sh_reg)) begin
          isp_en_next = 1'b0;
        end
      end
      TAP_CAP_DR: begin
        dr_next = '0;
        if (dec_ir == INS_IDCODE) begin
          dr_next = ID_WORD;
        end else if (is_isp(dec_ir)) begin
          dr_next[ISP_W-1:0] = (dec_ir == INS_VERIFY) ? {isp_reg[ISP_W-1:ROW_W], rb_reg}
                                                      : isp_reg;
        end
      end
      TAP_SHIFT_DR: begin
        dr_next = dr_reg >> 1;
        if (dec_ir == INS_IDCODE) begin
          dr_next[ID_W-1] = tdi_i;
        end else if (is_isp(dec_ir)) begin
          dr_next[ISP_W-1] = tdi_i;
        end else begin
          dr_next[BYP_W-1] = tdi_i;
        end
      end
      TAP_UPD_DR: begin
        armed_next = 1'b1;
        // the sys side reads this word live; nothing here holds it while an op is pending, only the programmer's idle waits keep it still
        if (is_isp(dec_ir)) begin
          isp_next = dr_reg[ISP_W-1:0];
        end
      end
      TAP_IDLE: begin
        // one array operation per entry into idle, never two in flight
        if (armed_reg && !pending) begin
          armed_next = 1'b0;
          if (isp_en_reg && is_op(ir_reg)) begin
            req_next = ~req_reg;
            case (ir_reg)
              INS_ERASE:   op_next = OP_ERASE;
              INS_PROGRAM: op_next = OP_PROGRAM;
              default:     op_next = OP_VERIFY;
            endcase
          end
        end
      end
      default: ;
    endcase
    // rd_reg settles on the sys edge that toggles ack, long before the toggle lands here
    if (ack_edge) begin
      ack_seen_next = ack_s2_reg;
      if (op_reg == OP_VERIFY) begin
        rb_next = rd_reg;
      end
    end
  end

  // a slow level, so a plain two-flop synchroniser on the sys side is enough
  assign vfy_next = isp_en_reg && (ir_reg == INS_VERIFY);

  always_ff @(posedge tck_i or negedge rstn_i) begin
    if (!rstn_i) begin
      state_reg    <= TAP_RESET;
      ir_sh_reg    <= '0;
      ir_reg       <= IR_RESET;
      dr_reg       <= '0;
      isp_reg      <= '0;
      isp_en_reg   <= 1'b0;
      armed_reg    <= 1'b0;
      req_reg      <= 1'b0;
      op_reg       <= OP_ERASE;
      rb_reg       <= '0;
      ack_s1_reg   <= 1'b0;
      ack_s2_reg   <= 1'b0;
      ack_seen_reg <= 1'b0;
      vfy_reg      <= 1'b0;
    end else begin
      state_reg    <= state_next;
      ir_sh_reg    <= ir_sh_next;
      ir_reg       <= ir_next;
      dr_reg       <= dr_next;
      isp_reg      <= isp_next;
      isp_en_reg   <= isp_en_next;
      armed_reg    <= armed_next;
      req_reg      <= req_next;
      op_reg       <= op_next;
      rb_reg       <= rb_next;
      ack_s1_reg   <= ack_reg;
      ack_s2_reg   <= ack_s1_reg;
      ack_seen_reg <= ack_seen_next;
      vfy_reg      <= vfy_next;
    end
  end

  // serial output, updated on falling tck and floating outside shift states
  always_comb begin
    tdo_next = 1'b0;
    oe_next  = 1'b0;
    if (state_reg == TAP_SHIFT_IR) begin
      tdo_next = ir_sh_reg[0];
      oe_next  = 1'b1;
    end else if (state_reg == TAP_SHIFT_DR) begin
      tdo_next = dr_reg[0];
      oe_next  = 1'b1;
    end
  end

  always_ff @(negedge tck_i or negedge rstn_i) begin
    if (!rstn_i) begin
      tdo_reg <= 1'b0;
      oe_reg  <= 1'b0;
    end else begin
      tdo_reg <= tdo_next;
      oe_reg  <= oe_next;
    end
  end

  assign tdo_o    = tdo_reg;
  assign tdo_oe_o = oe_reg;

  // array side; op stays still until the ack returns, row and data only while no dr update lands meanwhile
  always_comb begin
    ack_next  = ack_reg;
    busy_next = 1'b0;
    rd_next   = rd_reg;
    mem_we    = 1'b0;
    mem_clr   = 1'b0;
    if (req_s2_reg != ack_reg) begin
      ack_next  = req_s2_reg;
      busy_next = 1'b1;
      case (op_reg)
        OP_ERASE:   mem_clr = 1'b1;
        OP_PROGRAM: mem_we  = 1'b1;
        OP_VERIFY:  rd_next = mem[isp_reg[ISP_W-1:ROW_W]];
        default:    ;
      endcase
    end
    // user pins show the configured pattern, not a fixed level
    uio_next = vfy_s2_reg ? verify_io_cfg_i : user_out_i;
  end

  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      req_s1_reg <= 1'b0;
      req_s2_reg <= 1'b0;
      ack_reg    <= 1'b0;
      busy_reg   <= 1'b0;
      rd_reg     <= '0;
      vfy_s1_reg <= 1'b0;
      vfy_s2_reg <= 1'b0;
      uio_reg    <= '0;
    end else begin
      req_s1_reg <= req_reg;
      req_s2_reg <= req_s1_reg;
      ack_reg    <= ack_next;
      busy_reg   <= busy_next;
      rd_reg     <= rd_next;
      vfy_s1_reg <= vfy_reg;
      vfy_s2_reg <= vfy_s1_reg;
      uio_reg    <= uio_next;
    end
  end

  // nonvolatile cells keep their contents through reset
  always_ff @(posedge sys_clk_i) begin
    if (mem_clr) begin
      for (int i = 0; i < ROWS; i++) begin
        mem[i] <= '0;
      end
    end else if (mem_we) begin
      mem[isp_reg[ISP_W-1:ROW_W]] <= isp_reg[ROW_W-1:0];
    end
  end

  assign user_io_o = uio_reg;
  assign nv_busy_o = busy_reg;

endmodule

// >>> dv/isp_unit_properties.sv
`timescale 1ns/10ps
module isp_unit_checker (
  // clocks and reset
  input wire logic                          sys_clk_i,
  input wire logic                          rstn_i,
  input wire logic                          tck_i,
  // test access port
  input wire logic                          tms_i,
  input wire logic                          tdo_o,
  input wire logic                          tdo_oe_o,
  // user i/o and status
  input wire logic [isp_pkg::USER_IO_W-1:0] user_out_i,
  input wire logic [isp_pkg::USER_IO_W-1:0] verify_io_cfg_i,
  input wire logic [isp_pkg::USER_IO_W-1:0] user_io_o,
  input wire logic                          nv_busy_o
);
  a_float_idle: assert property (@(posedge tck_i) disable iff (!rstn_i)
    !tdo_oe_o |-> !tdo_o) else $error("tdo active while released");
  a_tap_reset_quiet: assert property (@(posedge tck_i) disable iff (!rstn_i)
    tms_i [*5] |-> !tdo_oe_o) else $error("tdo enabled after five tms high");
  a_shift_holds: assert property (@(posedge tck_i) disable iff (!rstn_i)
    tdo_oe_o && !tms_i |=> tdo_oe_o) else $error("tdo released inside shift");
  a_shift_exit: assert property (@(posedge tck_i) disable iff (!rstn_i)
    tdo_oe_o && tms_i |=> !tdo_oe_o) else $error("tdo kept after shift exit");
  a_shift_entry: assert property (@(posedge tck_i) disable iff (!rstn_i)
    $rose(tdo_oe_o) |-> !$past(tms_i) && (!$past(tms_i, 2) || !$past(tms_i, 3)))
    else $error("tdo enabled without capture or pause path");
  a_busy_spacing: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
    nv_busy_o |=> !nv_busy_o [*3]) else $error("array op pulses too close");
  a_user_io_src: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
    $past(rstn_i) |-> user_io_o == $past(user_out_i) || user_io_o == $past(verify_io_cfg_i))
    else $error("user pins from unknown source");
  a_reset_quiet: assert property (@(posedge sys_clk_i)
    !rstn_i |-> !tdo_oe_o && !nv_busy_o && user_io_o == '0) else $error("outputs live in reset");
  c_busy: cover property (@(posedge sys_clk_i) nv_busy_o);
  c_shift: cover property (@(posedge tck_i) $rose(tdo_oe_o));
  c_verify_pins: cover property (@(posedge sys_clk_i) user_io_o == verify_io_cfg_i);
endmodule

bind jtag_isp_unit isp_unit_checker isp_unit_checker_inst (
  .sys_clk_i(sys_clk_i), .rstn_i(rstn_i), .tck_i(tck_i), .tms_i(tms_i),
  .tdo_o(tdo_o), .tdo_oe_o(tdo_oe_o), .user_out_i(user_out_i),
  .verify_io_cfg_i(verify_io_cfg_i), .user_io_o(user_io_o), .nv_busy_o(nv_busy_o)
);

// >>> dv/isp_programmer_model.sv
`timescale 1ns/10ps
module isp_programmer_model (
  // test access port
  output logic      tck_o,
  output logic      tms_o,
  output logic      tdi_o,
  input  wire logic tdo_i
);
  logic run = 1'b0;
  initial begin
    tck_o = 1'b0;
    tms_o = 1'b1;
    tdi_o = 1'b1;
  end
  // test clock only runs inside a frame and parks low between frames
  always #3 tck_o = run ? ~tck_o : 1'b0;
  task step(input logic m, input logic d, output logic q);
    @(negedge tck_o);
    tms_o <= m;
    tdi_o <= d;
    @(posedge tck_o);
    q = tdo_i;
  endtask
  task go_idle();
    logic q;
    run = 1'b1;
    repeat (5) step(1'b1, 1'b1, q);
    step(1'b0, 1'b1, q);
    run = 1'b0;
  endtask
  // starts and ends in idle; tdi sits at its pull-up level outside shift
  task scan(input bit ir, input int n, input logic [31:0] din, input int idle,
            output logic [31:0] dout);
    logic q;
    dout = '0;
    run = 1'b1;
    step(1'b1, 1'b1, q);
    if (ir) step(1'b1, 1'b1, q);
    step(1'b0, 1'b1, q);
    step(1'b0, 1'b1, q);
    for (int i = 0; i < n; i++) begin
      step(i == n - 1, din[i], q);
      dout[i] = q;
    end
    step(1'b1, 1'b1, q);
    repeat (idle) step(1'b0, 1'b1, q);
    run = 1'b0;
  endtask
endmodule

// >>> dv/jtag_isp_command_unit_tb_top.sv
`timescale 1ns/10ps
module jtag_isp_command_unit_tb_top;
  import isp_pkg::*;
  logic                 sys_clk_i = 1'b0;
  logic                 rstn_i = 1'b1;
  logic                 tck, tms, tdi, tdo_o, tdo_oe_o, nv_busy_o;
  logic [USER_IO_W-1:0] user_out_i = 8'h00;
  logic [USER_IO_W-1:0] verify_io_cfg_i = 8'h00;
  logic [USER_IO_W-1:0] user_io_o;
  logic [31:0]          d;
  int                   bad_count = 0;
  int                   n_tests = 0;
  int                   busy_cnt = 0;
  // pull-up on the released data output
  wire                  tdo_line = tdo_oe_o ? tdo_o : 1'b1;

  jtag_isp_unit jtag_isp_unit_inst (.sys_clk_i(sys_clk_i), .rstn_i(rstn_i), .tck_i(tck),
    .tms_i(tms), .tdi_i(tdi), .tdo_o(tdo_o), .tdo_oe_o(tdo_oe_o), .user_out_i(user_out_i),
    .verify_io_cfg_i(verify_io_cfg_i), .user_io_o(user_io_o), .nv_busy_o(nv_busy_o));
  isp_programmer_model isp_programmer_model_inst (.tck_o(tck), .tms_o(tms), .tdi_o(tdi),
    .tdo_i(tdo_line));

  always #10 sys_clk_i = ~sys_clk_i;
  always @(posedge sys_clk_i) if (nv_busy_o === 1'b1) busy_cnt++;

  task check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask
  task sc(input bit ir, input int n, input logic [31:0] din, input int idle);
    isp_programmer_model_inst.scan(ir, n, din, idle, d);
  endtask
  task test_idcode();
    sc(1'b0, ID_W, '1, 2);
    check(d, ID_WORD);
  endtask
  task test_bypass();
    sc(1'b1, IR_W, 32'hF, 2);
    check(d[3:0], IR_CAPTURE);
    sc(1'b0, 8, 32'hA5, 2);
    check(d, 32'h4A);
  endtask
  task test_refused();
    int b;
    b = busy_cnt;
    sc(1'b1, IR_W, INS_PROGRAM, 40);
    sc(1'b0, 8, 32'hA5, 40);
    check(d, 32'h4A);
    check(busy_cnt, b);
  endtask
  task test_isp();
    int b;
    b = busy_cnt;
    sc(1'b1, IR_W, INS_ENABLE, 40);
    sc(1'b1, IR_W, INS_ERASE, 40);
    check(busy_cnt, b + 1);
    sc(1'b1, IR_W, INS_PROGRAM, 40);
    sc(1'b0, ISP_W, {5'h07, 16'hBEEF}, 40);
    check(busy_cnt, b + 3);
    sc(1'b1, IR_W, INS_VERIFY, 40);
    sc(1'b0, ISP_W, {5'h07, 16'h0000}, 40);
    check(user_io_o, verify_io_cfg_i);
    sc(1'b0, ISP_W, '0, 40);
    check(d, {11'h000, 5'h07, 16'hBEEF});
    check(busy_cnt, b + 6);
    sc(1'b1, IR_W, INS_ERASE, 40);
    sc(1'b1, IR_W, INS_VERIFY, 40);
    sc(1'b0, ISP_W, {5'h07, 16'h0000}, 40);
    sc(1'b0, ISP_W, '0, 40);
    check(d, {11'h000, 5'h07, 16'h0000});
    check(busy_cnt, b + 10);
    // long idle so the released verify level crosses into the sys domain
    sc(1'b1, IR_W, INS_IDCODE, 40);
    check(user_io_o, user_out_i);
    test_idcode();
  endtask
  task test_reset();
    int b;
    sc(1'b1, IR_W, INS_ENABLE, 8);
    @(posedge sys_clk_i);
    rstn_i <= 1'b0;
    repeat (4) @(posedge sys_clk_i);
    rstn_i <= 1'b1;
    @(posedge sys_clk_i);
    isp_programmer_model_inst.go_idle();
    test_idcode();
    b = busy_cnt;
    sc(1'b1, IR_W, INS_ERASE, 40);
    sc(1'b0, 8, 32'hA5, 40);
    check(d, 32'h4A);
    check(busy_cnt, b);
  endtask
  task test_done();
    $display("comparisons %0d, mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  initial begin
    #100000;
    bad_count++;
    test_done();
  end
  initial begin
    // fall in the nonblocking region of time zero so every asynchronous reset process sees the edge
    rstn_i <= 1'b0;
    repeat (20) @(posedge sys_clk_i);
    rstn_i <= 1'b1;
    user_out_i <= 8'h3C;
    verify_io_cfg_i <= 8'hC3;
    @(posedge sys_clk_i);
    isp_programmer_model_inst.go_idle();
    test_idcode();
    test_bypass();
    test_refused();
    test_isp();
    test_reset();
    test_done();
  end
endmodule
